// file: pkg/diag_steps_pkg.sv
// Shared constants and types for the conversion routine diagnostic step sequencer.
package diag_steps_pkg;

  localparam int CLK_PERIOD_NS = 20;

  localparam int NUM_GPIO  = 9;
  localparam int NUM_CELL  = 14;
  localparam int NUM_TERM  = 15;
  localparam int NUM_BIST  = 9;
  localparam int CODE_W    = 16;
  localparam int CNT_W     = 12;
  localparam int CYC_W     = 11;
  localparam int NUM_REQ   = 5;
  localparam int SYNC_W    = NUM_GPIO + NUM_TERM + NUM_CELL + NUM_BIST;

  // Step timing in nanoseconds; least times, so cycle counts round up.
  localparam int T_ADC_BASE_NS      = 2000;
  localparam int T_GPIO_OPEN_SET_NS = 1000;
  localparam int T_CX_OPEN_SET_NS   = 1000;
  localparam int T_BAL_OL_NS        = 4000;

  localparam logic [CNT_W-1:0] ADC_BASE_CYC  = CNT_W'((T_ADC_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] GPIO_SET_CYC  = CNT_W'((T_GPIO_OPEN_SET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] CX_SET_CYC    = CNT_W'((T_CX_OPEN_SET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] BAL_OL_CYC    = CNT_W'((T_BAL_OL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Request vector bit positions, in routine order.
  localparam int REQ_GPIO_CONV = 0;
  localparam int REQ_GPIO_OPEN = 1;
  localparam int REQ_CELL_OPEN = 2;
  localparam int REQ_BAL_OPEN  = 3;
  localparam int REQ_SELF      = 4;

  // Self-check fault vector bit positions.
  localparam int BIST_CELL_PATH = 0;
  localparam int BIST_OPEN_PATH = 1;
  localparam int BIST_PIN_PATH  = 2;
  localparam int BIST_VBAT_CMP  = 3;
  localparam int BIST_VREG_CMP  = 4;
  localparam int BIST_VCOM_CMP  = 5;
  localparam int BIST_VREF_CMP  = 6;
  localparam int BIST_BAL_HS    = 7;
  localparam int BIST_BAL_LS    = 8;

  localparam logic [1:0] GPIO_CFG_ANALOG = 2'h0;
  localparam logic [2:0] PERIOD_OFF      = 3'h0;
  localparam int         FIRST_TEST_PIN  = 2;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CELL,
    ST_VBAT,
    ST_GPIO,
    ST_GPIO_OPEN,
    ST_CELL_OPEN,
    ST_BAL_OPEN,
    ST_SELF_CHECK
  } step_t;

endpackage : diag_steps_pkg

// file: hdl/sync_agree.sv
// Three-stage input synchroniser that accepts a change once the last two stages agree.
`timescale 1ns/1ps
module sync_agree #(
  parameter int W = 1
) (
  input  wire logic         clk_i,   // System clock.
  input  wire logic         rstn_i,  // Synchronous reset, active low.
  input  wire logic [W-1:0] d_i,     // Asynchronous inputs.
  output logic      [W-1:0] q_o      // Filtered synchronous levels.
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] q_nxt;

  genvar gi;
  generate
    for (gi = 0; gi < W; gi++)
    begin : g_bit
      assign q_nxt[gi] = (s2_r[gi] == s3_r[gi]) ? s3_r[gi] : q_o[gi];
    end
  endgenerate

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      q_o  <= '0;
    end
    else
    begin
      s1_r <= d_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_o  <= q_nxt;
    end
  end

endmodule : sync_agree

// file: hdl/diag_steps.sv
// Sequencer for the optional diagnostic steps of the voltage conversion routine.
//
// Overview of operation
// - Cell conversion always runs first.
// - Period code zero excludes step from cyclic routines.
// - Pin open check requested with start or period.
// - Cell open check requested with start or period.
// - Balance check requested with start or period.
// - Self-check requested with start or period.
// - Pin below overtemp threshold raises overtemp flag.
// - Pin above undertemp threshold raises undertemp flag.
// - Fast-charge overtemp flag, threshold plus delta, maskable.
// - Pins one, two never tested; others need analog.
// - Pin below open level under pull-down flags open.
// - Crosscheck bit selects cell open check mode.
// - Terminal tested only when its cell enabled.
// - Cell open step lasts twice settle plus cycle.
// - Excess series drop flags the cell wire open.
// - Balance segments tested only for enabled cells.
// - Low switch drop flags balance path open.
// - Self-check tests all paths and comparators, no skips.
// - Separate path fail flags for cell, open, pin.
// - Separate fail flags for four supply comparators.
// - Separate high-side and low-side balance fail flags.
// - Self-check sets done flag, cleared on host read.
`timescale 1ns/1ps
module diag_steps
  import diag_steps_pkg::*;
(
  input  wire logic                       CLOCK_I,           // System clock, 50 MHz.
  input  wire logic                       RSTN_I,            // Synchronous reset, active low.
  input  wire logic                       SOC_I,             // On-demand start pulse.
  input  wire logic                       GPIO_CONV_REQ_I,   // Include pin conversion on demand.
  input  wire logic                       GPIO_OPEN_CHECK_REQUEST_I,    // Include pin open check.
  input  wire logic                       CELL_OPEN_CHECK_REQUEST_I,    // Include cell open check.
  input  wire logic                       BALANCE_OPEN_CHECK_REQUEST_I, // Include balance check.
  input  wire logic                       SELF_CHECK_REQUEST_I,         // Include self-check.
  input  wire logic                       CYCLIC_EN_I,       // Cyclic operation enabled.
  input  wire logic                       CYCLE_TICK_I,      // Cyclic timer pulse.
  input  wire logic [2:0]                 GPIO_CONV_PERIOD_I,           // Pin conversion period code.
  input  wire logic [2:0]                 GPIO_OPEN_PERIOD_I,           // Pin open period code.
  input  wire logic [2:0]                 CELL_OPEN_PERIOD_I,           // Cell open period code.
  input  wire logic [2:0]                 BALANCE_OPEN_CHECK_PERIOD_I,  // Balance period code.
  input  wire logic [2:0]                 SELF_CHECK_PERIOD_I,          // Self-check period code.
  input  wire logic [2:0]                 CONVERTER_CYCLE_TIME_I,       // Filter setting.
  input  wire logic                       CONVERTER_CROSSCHECK_SELECT_I, // Cell open mode.
  input  wire logic [NUM_CELL-1:0]        CELL_CHANNEL_ENABLE_I,        // Cell enables.
  input  wire logic [2*NUM_GPIO-1:0]      GPIO_CONFIG_I,     // Two bits per pin.
  input  wire logic [NUM_GPIO*CODE_W-1:0] GPIO_CODE_I,       // Converted pin codes.
  input  wire logic [CODE_W-1:0]          OT_THRESHOLD_I,    // Overtemp threshold.
  input  wire logic [CODE_W-1:0]          UT_THRESHOLD_I,    // Undertemp threshold.
  input  wire logic [CODE_W-1:0]          FASTCHARGE_DELTA_I, // Fast-charge delta.
  input  wire logic [NUM_GPIO-1:0]        FASTCHARGE_OVERTEMP_MASK_I,   // Fast-charge masks.
  input  wire logic [NUM_GPIO-1:0]        GPIO_LOW_CMP_I,    // Pin below open level.
  input  wire logic [NUM_TERM-1:0]        TERM_DROP_CMP_I,   // Series drop above threshold.
  input  wire logic [NUM_CELL-1:0]        BAL_DROP_LOW_CMP_I, // Switch drop below threshold.
  input  wire logic [NUM_BIST-1:0]        BIST_FAULT_I,      // Self-test fault levels.
  input  wire logic                       DONE_READ_I,       // Host read of done flag.
  output logic                            BUSY_O,            // Routine in progress.
  output logic [2:0]                      STEP_O,            // Current step.
  output logic                            CONFIG_OVERRIDE_O, // Failure pulse.
  output logic [NUM_GPIO-1:0]             PULLDOWN_EN_O,     // Pin test current on.
  output logic [NUM_GPIO-1:0]             PIN_OVERTEMP_FLAG_O,          // Overtemp flags.
  output logic [NUM_GPIO-1:0]             PIN_UNDERTEMP_FLAG_O,         // Undertemp flags.
  output logic [NUM_GPIO-1:0]             PIN_FASTCHARGE_OVERTEMP_FLAG_O, // Fast-charge flags.
  output logic [NUM_GPIO-1:0]             PIN_OPEN_FLAG_O,   // Pin open flags.
  output logic [NUM_TERM-1:0]             CELL_WIRE_OPEN_FLAG_O,        // Terminal open flags.
  output logic [NUM_CELL-1:0]             BALANCE_PATH_OPEN_FLAG_O,     // Balance open flags.
  output logic [NUM_BIST-1:0]             SELFTEST_FAIL_O,   // Self-test fail flags.
  output logic                            SELF_CHECK_DONE_FLAG_O        // Self-check done.
);

  function automatic logic period_hit(input logic [2:0] code, input logic [CYC_W-1:0] cnt);
    logic [CYC_W-1:0] mask;
    mask = '0;
    unique case (code)
      3'h0: mask = 11'h000;
      3'h1: mask = 11'h000;
      3'h2: mask = 11'h003;
      3'h3: mask = 11'h00F;
      3'h4: mask = 11'h03F;
      3'h5: mask = 11'h07F;
      3'h6: mask = 11'h1FF;
      3'h7: mask = 11'h3FF;
    endcase
    return (code != PERIOD_OFF) && ((cnt & mask) == '0);
  endfunction : period_hit

  function automatic step_t step_of(input int idx);
    step_t s;
    s = ST_IDLE;
    unique case (idx)
      REQ_GPIO_CONV: s = ST_GPIO;
      REQ_GPIO_OPEN: s = ST_GPIO_OPEN;
      REQ_CELL_OPEN: s = ST_CELL_OPEN;
      REQ_BAL_OPEN:  s = ST_BAL_OPEN;
      REQ_SELF:      s = ST_SELF_CHECK;
      default:       s = ST_IDLE;
    endcase
    return s;
  endfunction : step_of

  // First requested step at or after position from, else back to idle.
  function automatic step_t pick(input logic [NUM_REQ-1:0] r, input int from);
    step_t s;
    s = ST_IDLE;
    for (int i = NUM_REQ - 1; i >= 0; i--)
    begin
      if (i >= from && r[i])
        s = step_of(i);
    end
    return s;
  endfunction : pick

  step_t                 state_r, state_nxt;
  logic [CNT_W-1:0]      cnt_r, len_nxt, adc_cyc, cell_half;
  logic [CYC_W-1:0]      cyc_cnt_r;
  logic [NUM_REQ-1:0]    req_r, req_nxt;
  logic [NUM_TERM-1:0]   term_mid_r, wire_r, term_drop_s, term_tested, term_open;
  logic                  busy_r, override_r, done_r, cyc_start, start, step_end, fail_now;
  logic [NUM_GPIO-1:0]   pd_r, ot_r, ut_r, fc_r, open_r, gpio_low_s, pin_tested, ot_hit, ut_hit, fc_hit;
  logic [NUM_CELL-1:0]   bal_r, bal_low_s;
  logic [NUM_BIST-1:0]   bist_r, bist_s;
  logic [SYNC_W-1:0]     sync_q;

  sync_agree #(
    .W (SYNC_W)
  ) u_sync (
    .clk_i  (CLOCK_I),
    .rstn_i (RSTN_I),
    .d_i    ({BIST_FAULT_I, BAL_DROP_LOW_CMP_I, TERM_DROP_CMP_I, GPIO_LOW_CMP_I}),
    .q_o    (sync_q)
  );

  assign gpio_low_s  = sync_q[NUM_GPIO-1:0];
  assign term_drop_s = sync_q[NUM_GPIO+NUM_TERM-1:NUM_GPIO];
  assign bal_low_s   = sync_q[NUM_GPIO+NUM_TERM+NUM_CELL-1:NUM_GPIO+NUM_TERM];
  assign bist_s      = sync_q[SYNC_W-1:NUM_GPIO+NUM_TERM+NUM_CELL];

  // The converter cycle stretches linearly with the filter setting.
  assign adc_cyc   = CNT_W'(ADC_BASE_CYC * (CNT_W'(CONVERTER_CYCLE_TIME_I) + 12'h001));
  assign cell_half = CX_SET_CYC + adc_cyc;
  assign cyc_start = CYCLIC_EN_I && CYCLE_TICK_I && !SOC_I;
  assign start     = (state_r == ST_IDLE) && (SOC_I || cyc_start);
  assign step_end  = (state_r != ST_IDLE) && (cnt_r == 12'h001);

  // On demand the request bits travel with the start; cyclically each period code decides.
  assign req_nxt = SOC_I ?
    {SELF_CHECK_REQUEST_I, BALANCE_OPEN_CHECK_REQUEST_I, CELL_OPEN_CHECK_REQUEST_I,
     GPIO_OPEN_CHECK_REQUEST_I, GPIO_CONV_REQ_I} :
    {period_hit(SELF_CHECK_PERIOD_I, cyc_cnt_r), period_hit(BALANCE_OPEN_CHECK_PERIOD_I, cyc_cnt_r),
     period_hit(CELL_OPEN_PERIOD_I, cyc_cnt_r), period_hit(GPIO_OPEN_PERIOD_I, cyc_cnt_r),
     period_hit(GPIO_CONV_PERIOD_I, cyc_cnt_r)};

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE:       state_nxt = start ? ST_CELL : ST_IDLE;
      ST_CELL:       state_nxt = ST_VBAT;
      ST_VBAT:       state_nxt = pick(req_r, REQ_GPIO_CONV);
      ST_GPIO:       state_nxt = pick(req_r, REQ_GPIO_OPEN);
      ST_GPIO_OPEN:  state_nxt = pick(req_r, REQ_CELL_OPEN);
      ST_CELL_OPEN:  state_nxt = pick(req_r, REQ_BAL_OPEN);
      ST_BAL_OPEN:   state_nxt = pick(req_r, REQ_SELF);
      ST_SELF_CHECK: state_nxt = ST_IDLE;
    endcase
  end

  always_comb
  begin
    len_nxt = 12'h001;
    unique case (state_nxt)
      ST_IDLE:       len_nxt = 12'h000;
      ST_CELL:       len_nxt = adc_cyc;
      ST_VBAT:       len_nxt = adc_cyc;
      ST_GPIO:       len_nxt = ADC_BASE_CYC;
      ST_GPIO_OPEN:  len_nxt = CNT_W'(GPIO_SET_CYC + ADC_BASE_CYC);
      ST_CELL_OPEN:  len_nxt = CNT_W'({cell_half, 1'b0});
      ST_BAL_OPEN:   len_nxt = CNT_W'({BAL_OL_CYC, 1'b0});
      ST_SELF_CHECK: len_nxt = CNT_W'(ADC_BASE_CYC * 12'h003);
    endcase
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_GPIO; gi++)
    begin : g_pin
      logic [CODE_W-1:0] code;
      logic [CODE_W:0]   fc_level;
      assign code     = GPIO_CODE_I[gi*CODE_W +: CODE_W];
      assign fc_level = {1'b0, OT_THRESHOLD_I} + {1'b0, FASTCHARGE_DELTA_I};
      assign pin_tested[gi] = (gi >= FIRST_TEST_PIN) &&
                              (GPIO_CONFIG_I[2*gi +: 2] == GPIO_CFG_ANALOG);
      assign ot_hit[gi] = pin_tested[gi] && (code < OT_THRESHOLD_I);
      assign ut_hit[gi] = pin_tested[gi] && (code > UT_THRESHOLD_I);
      assign fc_hit[gi] = pin_tested[gi] && ({1'b0, code} < fc_level) &&
                          !FASTCHARGE_OVERTEMP_MASK_I[gi];
    end
    for (gi = 0; gi < NUM_TERM; gi++)
    begin : g_term
      assign term_tested[gi] = CELL_CHANNEL_ENABLE_I[(gi == 0) ? 0 : gi - 1];
      // Crosscheck mode confirms an open on both halves; plain mode takes either half.
      assign term_open[gi] = term_tested[gi] && (CONVERTER_CROSSCHECK_SELECT_I ?
                             (term_mid_r[gi] && term_drop_s[gi]) :
                             (term_mid_r[gi] || term_drop_s[gi]));
    end
  endgenerate

  always_comb
  begin
    fail_now = 1'b0;
    unique case (state_r)
      ST_GPIO:       fail_now = |{ot_hit, ut_hit, fc_hit};
      ST_GPIO_OPEN:  fail_now = |(gpio_low_s & pin_tested);
      ST_CELL_OPEN:  fail_now = |term_open;
      ST_BAL_OPEN:   fail_now = |(bal_low_s & CELL_CHANNEL_ENABLE_I);
      ST_SELF_CHECK: fail_now = |bist_s;
      default:       fail_now = 1'b0;
    endcase
  end

  always_ff @(posedge CLOCK_I)
  begin
    if (!RSTN_I)
    begin
      state_r    <= ST_IDLE;
      cnt_r      <= '0;
      cyc_cnt_r  <= '0;
      req_r      <= '0;
      term_mid_r <= '0;
      busy_r     <= 1'b0;
      override_r <= 1'b0;
      pd_r       <= '0;
    end
    else
    begin
      override_r <= step_end && fail_now;
      if (start || step_end)
      begin
        state_r <= state_nxt;
        cnt_r   <= len_nxt;
        busy_r  <= (state_nxt != ST_IDLE);
        pd_r    <= (state_nxt == ST_GPIO_OPEN) ? pin_tested : '0;
      end
      else if (state_r != ST_IDLE)
        cnt_r <= cnt_r - 12'h001;
      if (start)
        req_r <= req_nxt;
      if (start && cyc_start)
        cyc_cnt_r <= cyc_cnt_r + 11'h001;
      if (state_r == ST_CELL_OPEN && cnt_r == cell_half)
        term_mid_r <= term_drop_s;
    end
  end

  // Result flags hold the outcome of the last run of their step.
  always_ff @(posedge CLOCK_I)
  begin
    if (!RSTN_I)
    begin
      ot_r   <= '0;
      ut_r   <= '0;
      fc_r   <= '0;
      open_r <= '0;
      wire_r <= '0;
      bal_r  <= '0;
      bist_r <= '0;
      done_r <= 1'b0;
    end
    else
    begin
      if (step_end && state_r == ST_GPIO)
      begin
        ot_r <= ot_hit;
        ut_r <= ut_hit;
        fc_r <= fc_hit;
      end
      if (step_end && state_r == ST_GPIO_OPEN)
        open_r <= gpio_low_s & pin_tested;
      if (step_end && state_r == ST_CELL_OPEN)
        wire_r <= term_open;
      if (step_end && state_r == ST_BAL_OPEN)
        bal_r <= bal_low_s & CELL_CHANNEL_ENABLE_I;
      if (step_end && state_r == ST_SELF_CHECK)
        bist_r <= bist_s;
      // A completion in the same cycle as the host read keeps the flag set.
      if (step_end && state_r == ST_SELF_CHECK)
        done_r <= 1'b1;
      else if (DONE_READ_I)
        done_r <= 1'b0;
    end
  end

  assign BUSY_O                         = busy_r;
  assign STEP_O                         = 3'(state_r);
  assign CONFIG_OVERRIDE_O              = override_r;
  assign PULLDOWN_EN_O                  = pd_r;
  assign PIN_OVERTEMP_FLAG_O            = ot_r;
  assign PIN_UNDERTEMP_FLAG_O           = ut_r;
  assign PIN_FASTCHARGE_OVERTEMP_FLAG_O = fc_r;
  assign PIN_OPEN_FLAG_O                = open_r;
  assign CELL_WIRE_OPEN_FLAG_O          = wire_r;
  assign BALANCE_PATH_OPEN_FLAG_O       = bal_r;
  assign SELFTEST_FAIL_O                = bist_r;
  assign SELF_CHECK_DONE_FLAG_O         = done_r;

  a_cell_first: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
    start |=> state_r == ST_CELL ##[1:1000] state_r == ST_VBAT)
    else $error("routine did not open with cell conversion");
  a_period_off: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
    (start && cyc_start && SELF_CHECK_PERIOD_I == PERIOD_OFF) |=> !req_r[REQ_SELF])
    else $error("excluded step was scheduled");
  a_step_order: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
    (step_end && state_r == ST_BAL_OPEN) |=> (state_r == ST_SELF_CHECK || state_r == ST_IDLE))
    else $error("step order broken after balance check");
  a_open_request: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
    (state_r == ST_IDLE && SOC_I && GPIO_OPEN_CHECK_REQUEST_I) |=> req_r[REQ_GPIO_OPEN])
    else $error("pin open request lost");
  a_pins_skipped: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
    PULLDOWN_EN_O[1:0] == 2'h0 && PIN_OPEN_FLAG_O[1:0] == 2'h0)
    else $error("first two pins were tested");
  a_pulldown_step: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
    (PULLDOWN_EN_O != '0) |-> state_r == ST_GPIO_OPEN)
    else $error("test current outside open check");
  a_cell_length: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
    (state_r != ST_CELL_OPEN ##1 state_r == ST_CELL_OPEN) |-> cnt_r == CNT_W'(2 * (CX_SET_CYC + adc_cyc)))
    else $error("cell open step length wrong");
  a_supply_flags: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
    (step_end && state_r == ST_SELF_CHECK && bist_s[BIST_VCOM_CMP])
    |=> SELFTEST_FAIL_O[BIST_VCOM_CMP] && CONFIG_OVERRIDE_O)
    else $error("supply comparator fail not flagged");
  a_done_set: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
    (step_end && state_r == ST_SELF_CHECK) |=> SELF_CHECK_DONE_FLAG_O && CONFIG_OVERRIDE_O == $past(fail_now))
    else $error("self-check done flag not set");

endmodule : diag_steps

// file: tb/host_model.sv
// Behavioural host that starts routines and reads the self-check done flag.
`timescale 1ns/1ps
module host_model (
  input  wire logic       clk_i,       // System clock.
  output logic            soc_o,       // Start pulse.
  output logic [4:0]      req_o,       // Step requests, routine order.
  output logic            done_read_o  // Done flag read strobe.
);
  initial
  begin
    soc_o = 1'b0;
    req_o = 5'h0;
    done_read_o = 1'b0;
  end
  // Requests are dropped with the start, so a late sample sees no request.
  task automatic start(input logic [4:0] req);
    @(posedge clk_i);
    soc_o <= 1'b1;
    req_o <= req;
    @(posedge clk_i);
    soc_o <= 1'b0;
    req_o <= 5'h0;
  endtask : start
  task automatic read_done();
    @(posedge clk_i);
    done_read_o <= 1'b1;
    @(posedge clk_i);
    done_read_o <= 1'b0;
  endtask : read_done
endmodule : host_model

// file: tb/conversion_routine_diag_steps_tb_top.sv
// Self-checking testbench for the diagnostic step sequencer.
`timescale 1ns/1ps
module conversion_routine_diag_steps_tb_top;
  import diag_steps_pkg::*;
  logic CLOCK_I = 1'b0, RSTN_I = 1'b0, CYCLIC_EN_I = 1'b0, CYCLE_TICK_I = 1'b0, CONVERTER_CROSSCHECK_SELECT_I = 1'b0;
  wire SOC_I, GPIO_CONV_REQ_I, GPIO_OPEN_CHECK_REQUEST_I, CELL_OPEN_CHECK_REQUEST_I, BALANCE_OPEN_CHECK_REQUEST_I;
  wire SELF_CHECK_REQUEST_I, DONE_READ_I;
  logic [2:0] GPIO_CONV_PERIOD_I = 3'h0, GPIO_OPEN_PERIOD_I = 3'h0, CELL_OPEN_PERIOD_I = 3'h0;
  logic [2:0] BALANCE_OPEN_CHECK_PERIOD_I = 3'h0, SELF_CHECK_PERIOD_I = 3'h0, CONVERTER_CYCLE_TIME_I = 3'h0;
  logic [NUM_CELL-1:0] CELL_CHANNEL_ENABLE_I = 14'h2005, BAL_DROP_LOW_CMP_I = 14'h3FFF;
  logic [2*NUM_GPIO-1:0] GPIO_CONFIG_I = 18'h01000;
  logic [NUM_GPIO*CODE_W-1:0] GPIO_CODE_I = {16'h0BB8, 16'h0BB8, 16'h0064, 16'h04B0, 16'h04B0, 16'h1770,
                                            16'h0320, 16'h0BB8, 16'h0BB8};
  logic [CODE_W-1:0] OT_THRESHOLD_I = 16'h03E8, UT_THRESHOLD_I = 16'h1388, FASTCHARGE_DELTA_I = 16'h01F4;
  logic [NUM_GPIO-1:0] FASTCHARGE_OVERTEMP_MASK_I = 9'h020, GPIO_LOW_CMP_I = 9'h1FF;
  logic [NUM_TERM-1:0] TERM_DROP_CMP_I = 15'h7FFF;
  logic [NUM_BIST-1:0] BIST_FAULT_I = 9'h1A5;
  logic BUSY_O, CONFIG_OVERRIDE_O, SELF_CHECK_DONE_FLAG_O;
  logic [2:0] STEP_O;
  logic [NUM_GPIO-1:0] PULLDOWN_EN_O, PIN_OVERTEMP_FLAG_O, PIN_UNDERTEMP_FLAG_O, PIN_FASTCHARGE_OVERTEMP_FLAG_O;
  logic [NUM_GPIO-1:0] PIN_OPEN_FLAG_O;
  logic [NUM_TERM-1:0] CELL_WIRE_OPEN_FLAG_O;
  logic [NUM_CELL-1:0] BALANCE_PATH_OPEN_FLAG_O;
  logic [NUM_BIST-1:0] SELFTEST_FAIL_O;
  int cyc = 0, ov_cnt = 0, err_count = 0, check_count = 0;
  int st_q[$], tm_q[$];
  logic [2:0] last_s = 3'h0;
  logic [NUM_GPIO-1:0] pd_seen = '0;
  diag_steps u_dut (.*);
  host_model u_host (.clk_i(CLOCK_I), .soc_o(SOC_I), .done_read_o(DONE_READ_I),
    .req_o({SELF_CHECK_REQUEST_I, BALANCE_OPEN_CHECK_REQUEST_I, CELL_OPEN_CHECK_REQUEST_I,
            GPIO_OPEN_CHECK_REQUEST_I, GPIO_CONV_REQ_I}));
  always #10 CLOCK_I = ~CLOCK_I;
  // Step changes are logged with their cycle so lengths fall out as differences.
  always @(posedge CLOCK_I)
  begin
    cyc = cyc + 1;
    if (CONFIG_OVERRIDE_O === 1'b1) ov_cnt++;
    pd_seen = pd_seen | PULLDOWN_EN_O;
    if (STEP_O !== last_s)
    begin
      st_q.push_back(int'(STEP_O));
      tm_q.push_back(cyc);
      last_s = STEP_O;
    end
    if (cyc == 20000)
    begin
      err_count++;
      complete_run();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR at %0t: %s got %0h expected %0h", $time, msg, got, exp);
    end
  endtask : chk
  function automatic int dur(input logic [3:0] s, input int f);
    case (s)
      4'h1, 4'h2: dur = 100 * (f + 1);
      4'h3: dur = 100;
      4'h4: dur = 150;
      4'h5: dur = 2 * (50 + 100 * (f + 1));
      4'h6: dur = 400;
      default: dur = 300;
    endcase
  endfunction : dur
  task automatic arm();
    st_q.delete();
    tm_q.delete();
    ov_cnt = 0;
    pd_seen = '0;
  endtask : arm
  // Sequence is read a nibble at a time from the bottom, ending at step 0.
  task automatic check_run(input logic [31:0] seq, input int f);
    int n;
    n = 0;
    while (BUSY_O !== 1'b1 && n < 100) begin @(posedge CLOCK_I); n++; end
    while (BUSY_O !== 1'b0 && n < 5000) begin @(posedge CLOCK_I); n++; end
    @(posedge CLOCK_I);
    for (int i = 0; i < 8; i++)
    begin
      chk(32'(st_q.size() > i ? st_q[i] : 99), 32'(seq[4*i +: 4]), "step order");
      if (seq[4*i +: 4] == 4'h0 || st_q.size() < i + 2) break;
      chk(32'(tm_q[i+1] - tm_q[i]), 32'(dur(seq[4*i +: 4], f)), "step length");
    end
  endtask : check_run
  task automatic tick();
    @(posedge CLOCK_I);
    CYCLE_TICK_I <= 1'b1;
    @(posedge CLOCK_I);
    CYCLE_TICK_I <= 1'b0;
  endtask : tick
  task automatic test_self_walk();
    arm();
    u_host.start(5'h10);
    check_run(32'h0721, 0);
    chk(32'(SELFTEST_FAIL_O), 32'h1A5, "self fail flags");
    chk(32'(SELF_CHECK_DONE_FLAG_O), 32'h1, "done set");
    chk(32'(ov_cnt), 32'h1, "override pulses");
    u_host.read_done();
    repeat (2) @(posedge CLOCK_I);
    chk(32'(SELF_CHECK_DONE_FLAG_O), 32'h0, "done cleared");
    $display("test self_walk done");
  endtask : test_self_walk
  task automatic test_all_steps();
    @(posedge CLOCK_I);
    CONVERTER_CYCLE_TIME_I <= 3'h1;
    arm();
    u_host.start(5'h1F);
    check_run(32'h07654321, 1);
    chk(32'(PIN_OVERTEMP_FLAG_O), 32'h004, "overtemp");
    chk(32'(PIN_UNDERTEMP_FLAG_O), 32'h008, "undertemp");
    chk(32'(PIN_FASTCHARGE_OVERTEMP_FLAG_O), 32'h014, "fastcharge");
    chk(32'(PIN_OPEN_FLAG_O), 32'h1BC, "pin open");
    chk(32'(CELL_WIRE_OPEN_FLAG_O), 32'h400B, "wire open");
    chk(32'(BALANCE_PATH_OPEN_FLAG_O), 32'h2005, "balance open");
    chk(32'(ov_cnt), 32'h5, "override pulses");
    chk(32'(pd_seen), 32'h1BC, "pulldown pins");
    chk(32'(PULLDOWN_EN_O), 32'h0, "pulldown released");
    $display("test all_steps done");
  endtask : test_all_steps
  // Comparator drops back after the midpoint, so only terminals open at both samples stay flagged.
  task automatic test_crosscheck();
    @(posedge CLOCK_I);
    CONVERTER_CROSSCHECK_SELECT_I <= 1'b1;
    arm();
    u_host.start(5'h04);
    while (STEP_O !== 3'h5) @(posedge CLOCK_I);
    repeat (300) @(posedge CLOCK_I);
    TERM_DROP_CMP_I <= 15'h0001;
    check_run(32'h0521, 1);
    chk(32'(CELL_WIRE_OPEN_FLAG_O), 32'h0001, "crosscheck wire open");
    chk(32'(ov_cnt), 32'h1, "crosscheck override");
    $display("test crosscheck done");
  endtask : test_crosscheck
  task automatic test_cyclic();
    @(posedge CLOCK_I);
    BIST_FAULT_I <= 9'h000;
    BAL_DROP_LOW_CMP_I <= 14'h0000;
    SELF_CHECK_PERIOD_I <= 3'h1;
    BALANCE_OPEN_CHECK_PERIOD_I <= 3'h2;
    CYCLIC_EN_I <= 1'b1;
    repeat (8) @(posedge CLOCK_I);
    arm();
    tick();
    check_run(32'h07621, 1);
    chk(32'(SELFTEST_FAIL_O), 32'h000, "fail flags renewed");
    chk(32'(ov_cnt), 32'h0, "no override");
    chk(32'(BALANCE_PATH_OPEN_FLAG_O), 32'h0, "balance flags renewed");
    arm();
    tick();
    repeat (20) @(posedge CLOCK_I);
    tick();
    check_run(32'h0721, 1);
    repeat (20) @(posedge CLOCK_I);
    chk(32'(BUSY_O), 32'h0, "busy start ignored");
    SELF_CHECK_PERIOD_I <= 3'h0;
    arm();
    tick();
    check_run(32'h021, 1);
    $display("test cyclic done");
  endtask : test_cyclic
  task automatic complete_run();
    $display("Counts: %0d checks, %0d errors", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run
  initial
  begin
    repeat (4) @(posedge CLOCK_I);
    RSTN_I <= 1'b1;
    @(posedge CLOCK_I);
    chk(32'({BUSY_O, STEP_O, SELF_CHECK_DONE_FLAG_O}), 32'h0, "reset state");
    test_self_walk();
    test_all_steps();
    test_crosscheck();
    test_cyclic();
    complete_run();
  end
endmodule : conversion_routine_diag_steps_tb_top
